// *** rtl/rpf_pkg.sv ***
package rpf_pkg;
  localparam int DW = 24;
  localparam int MODW = 4;
  localparam int CW = 14;
  localparam int FW = 7;
  localparam int AW = 7;
  localparam int RW = 9;
  localparam int ACCW = 44;
  localparam int HW = DW + 4;
  localparam int DECW = 12;

  localparam logic [AW-1:0] ADDR_PWR_ONE = 7'h01;
  localparam logic [AW-1:0] ADDR_PWR_TWO = 7'h02;
  localparam logic [AW-1:0] ADDR_CONV_CTRL = 7'h0E;
  localparam logic [AW-1:0] ADDR_GAIN = 7'h0F;
  localparam logic [AW-1:0] ADDR_COEF_A_LO = 7'h1B;
  localparam logic [AW-1:0] ADDR_COEF_A_HI = 7'h1C;
  localparam logic [AW-1:0] ADDR_COEF_B_LO = 7'h1D;
  localparam logic [AW-1:0] ADDR_COEF_B_HI = 7'h1E;
  localparam logic [AW-1:0] ADDR_ROUTING = 7'h2C;
  localparam logic [AW-1:0] ADDR_AMP_VOL = 7'h2D;
  localparam logic [AW-1:0] ADDR_MIX = 7'h2F;

  localparam int BIT_BIAS_EN = 4;
  localparam int BIT_MIX_EN = 4;
  localparam int BIT_CONV_EN = 0;
  localparam int BIT_INVERT = 0;
  localparam int BIT_OSR = 3;
  localparam int BIT_HPF_EN = 8;
  localparam int BIT_HPF_APP = 7;
  localparam int HPF_CUT_LSB = 4;
  localparam int BIT_NOTCH_EN = 7;
  localparam int BIT_COMMIT = 8;
  localparam int BIT_BOOST = 8;
  localparam int AUX_LSB = 0;
  localparam int LINE_LSB = 4;
  localparam int BIT_BIAS_LVL = 8;
  localparam int BIT_ISOLATE = 6;

  localparam logic [RW-1:0] RST_PWR_ONE = 9'h000;
  localparam logic [RW-1:0] RST_PWR_TWO = 9'h000;
  localparam logic [RW-1:0] RST_CONV_CTRL = 9'h100;
  localparam logic [7:0] RST_GAIN = 8'hFF;
  localparam logic [RW-1:0] RST_ROUTING = 9'h003;
  localparam logic [RW-1:0] RST_AMP_VOL = 9'h010;
  localparam logic [RW-1:0] RST_MIX = 9'h100;

  localparam logic [6:0] OSR_LO_LAST = 7'h3F;
  localparam logic [6:0] OSR_HI_LAST = 7'h7F;
  localparam int DEC_SHIFT_LO = 14;
  localparam int DEC_SHIFT_HI = 13;
  localparam logic [4:0] HPF_AUDIO_SHIFT = 5'h0B;
  localparam int NOTCH_A_FRAC = 13;
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [7:0] GAIN_UNITY = 8'hFF;
  localparam logic [7:0] GAIN_STEPS_6DB = 8'h0C;
  localparam int MANT_FRAC = 15;

  // leak shift per cut-off code, relative to fs so it tracks the rate group
  function automatic logic [4:0] hpf_app_shift(input logic [2:0] cut);
    case (cut)
      3'h0: hpf_app_shift = 5'h07;
      3'h1: hpf_app_shift = 5'h07;
      3'h2: hpf_app_shift = 5'h06;
      3'h3: hpf_app_shift = 5'h06;
      3'h4: hpf_app_shift = 5'h05;
      3'h5: hpf_app_shift = 5'h05;
      3'h6: hpf_app_shift = 5'h05;
      default: hpf_app_shift = 5'h04;
    endcase
  endfunction

  // Q15 mantissa of -0.5 dB * k, k = 0..11
  function automatic logic [16:0] gain_mantissa(input logic [7:0] k);
    case (k)
      8'h00: gain_mantissa = 17'h08000;
      8'h01: gain_mantissa = 17'h078D7;
      8'h02: gain_mantissa = 17'h0721D;
      8'h03: gain_mantissa = 17'h06BB3;
      8'h04: gain_mantissa = 17'h065AD;
      8'h05: gain_mantissa = 17'h05FFD;
      8'h06: gain_mantissa = 17'h05A9E;
      8'h07: gain_mantissa = 17'h0558C;
      8'h08: gain_mantissa = 17'h050C3;
      8'h09: gain_mantissa = 17'h04C3F;
      8'h0A: gain_mantissa = 17'h047FB;
      default: gain_mantissa = 17'h043F4;
    endcase
  endfunction
endpackage

// *** rtl/rpf_record_path.sv ***
// Contract
// - boost bit gives amp path +20dB else 0dB
// - isolate bit disconnects amp path from mix
// - aux gain code 000 disconnects, else steps
// - line gain code 000 disconnects, else steps
// - mix stage powered only while enable set
// - bias level bit picks 0.9 or 0.6
// - bias output enabled by bit, else high-Z
// - converter enable runs converter and filters
// - invert bit flips record sample polarity
// - oversample bit selects 64x or 128x
// - decimate oversampled data to 24-bit samples
// - high-pass bypassed when its enable clear
// - audio mode: first-order high-pass near 3.7Hz
// - application mode: second-order, cut-off field selects
// - cut-off scales with sample rate group
// - two 14-bit coefficients split over four registers
// - coefficients take effect only on commit write
// - notch acts only while notch enable set
// - coefficients are negated fixed-point fractions
// - gain is 0.5dB times code minus 255
// - gain code zero mutes output
// - new gain waits for gain commit bit
`timescale 1ns/1ps
`default_nettype none
module rpf_record_path (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // register port from the control interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [rpf_pkg::AW-1:0] i_reg_addr,
  input wire logic [rpf_pkg::RW-1:0] i_reg_wdata,
  output logic [rpf_pkg::RW-1:0] o_reg_rdata,
  // oversampled converter data
  input wire logic i_mod_valid,
  input wire logic signed [rpf_pkg::MODW-1:0] i_mod_data,
  // record samples to the audio interface
  output logic o_smp_valid,
  output logic signed [rpf_pkg::DW-1:0] o_smp_data,
  // analogue controls
  output logic o_amp_path_connect,
  output logic o_amp_path_boost,
  output logic o_aux_connect,
  output logic [2:0] o_aux_gain_code,
  output logic o_line_connect,
  output logic [2:0] o_line_gain_code,
  output logic o_mix_stage_power,
  output logic o_bias_drive_en,
  output logic o_bias_level_low,
  output logic o_converter_power,
  output logic o_oversample_128
);
  localparam int DW = rpf_pkg::DW;
  localparam int HW = rpf_pkg::HW;
  localparam int ACCW = rpf_pkg::ACCW;
  localparam int CW = rpf_pkg::CW;
  localparam int FW = rpf_pkg::FW;
  localparam int RW = rpf_pkg::RW;

  function automatic logic wr_hit(input logic [rpf_pkg::AW-1:0] a);
    wr_hit = i_reg_wr && (i_reg_addr == a);
  endfunction

  function automatic logic signed [DW-1:0] sat(input logic signed [ACCW-1:0] v);
    // limits are signed so that negative values do not compare as large unsigned ones
    if (v > $signed(ACCW'({1'b0, {(DW-1){1'b1}}})))
      sat = {1'b0, {(DW-1){1'b1}}};
    else if (v < -$signed(ACCW'({1'b0, {(DW-1){1'b1}}})) - $signed(ACCW'(1)))
      sat = {1'b1, {(DW-1){1'b0}}};
    else
      sat = v[DW-1:0];
  endfunction

  logic [RW-1:0] pwr_one_reg, pwr_two_reg, conv_ctrl_reg, routing_reg, amp_vol_reg, mix_reg;
  logic [7:0] gain_code_reg, gain_act_reg;
  logic [FW-1:0] coef_a_lo_reg, coef_a_hi_reg, coef_b_lo_reg, coef_b_hi_reg;
  logic notch_en_reg, notch_pending_reg;
  logic signed [CW-1:0] coef_a_act_reg, coef_b_act_reg;
  logic notch_commit, gain_commit;

  assign notch_commit = i_reg_wdata[rpf_pkg::BIT_COMMIT] && (wr_hit(rpf_pkg::ADDR_COEF_A_LO)
    || wr_hit(rpf_pkg::ADDR_COEF_A_HI) || wr_hit(rpf_pkg::ADDR_COEF_B_LO)
    || wr_hit(rpf_pkg::ADDR_COEF_B_HI));
  assign gain_commit = wr_hit(rpf_pkg::ADDR_GAIN) && i_reg_wdata[rpf_pkg::BIT_COMMIT];

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pwr_one_reg <= rpf_pkg::RST_PWR_ONE;
      pwr_two_reg <= rpf_pkg::RST_PWR_TWO;
      conv_ctrl_reg <= rpf_pkg::RST_CONV_CTRL;
      routing_reg <= rpf_pkg::RST_ROUTING;
      amp_vol_reg <= rpf_pkg::RST_AMP_VOL;
      mix_reg <= rpf_pkg::RST_MIX;
    end
    else
    begin
      if (wr_hit(rpf_pkg::ADDR_PWR_ONE)) pwr_one_reg <= i_reg_wdata;
      if (wr_hit(rpf_pkg::ADDR_PWR_TWO)) pwr_two_reg <= i_reg_wdata;
      if (wr_hit(rpf_pkg::ADDR_CONV_CTRL)) conv_ctrl_reg <= i_reg_wdata;
      if (wr_hit(rpf_pkg::ADDR_ROUTING)) routing_reg <= i_reg_wdata;
      if (wr_hit(rpf_pkg::ADDR_AMP_VOL)) amp_vol_reg <= i_reg_wdata;
      if (wr_hit(rpf_pkg::ADDR_MIX)) mix_reg <= i_reg_wdata;
    end
  end

  // gain code is staged; the commit bit in the same write applies the new code
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gain_code_reg <= rpf_pkg::RST_GAIN;
      gain_act_reg <= rpf_pkg::RST_GAIN;
    end
    else
    begin
      if (wr_hit(rpf_pkg::ADDR_GAIN)) gain_code_reg <= i_reg_wdata[7:0];
      if (gain_commit) gain_act_reg <= i_reg_wdata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      coef_a_lo_reg <= '0;
      coef_a_hi_reg <= '0;
      coef_b_lo_reg <= '0;
      coef_b_hi_reg <= '0;
      notch_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_hit(rpf_pkg::ADDR_COEF_A_LO))
      begin
        coef_a_lo_reg <= i_reg_wdata[FW-1:0];
        notch_en_reg <= i_reg_wdata[rpf_pkg::BIT_NOTCH_EN];
      end
      if (wr_hit(rpf_pkg::ADDR_COEF_A_HI)) coef_a_hi_reg <= i_reg_wdata[FW-1:0];
      if (wr_hit(rpf_pkg::ADDR_COEF_B_LO)) coef_b_lo_reg <= i_reg_wdata[FW-1:0];
      if (wr_hit(rpf_pkg::ADDR_COEF_B_HI)) coef_b_hi_reg <= i_reg_wdata[FW-1:0];
    end
  end

  logic conv_en, dec_valid;
  logic signed [DW-1:0] dec_data;
  assign conv_en = pwr_two_reg[rpf_pkg::BIT_CONV_EN];

  // pending commit is taken at the next sample boundary; a new commit wins over the clear
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      notch_pending_reg <= 1'b0;
      coef_a_act_reg <= '0;
      coef_b_act_reg <= '0;
    end
    else
    begin
      notch_pending_reg <= notch_commit || (notch_pending_reg && !dec_valid);
      if (notch_pending_reg && dec_valid)
      begin
        coef_a_act_reg <= {coef_a_hi_reg, coef_a_lo_reg};
        coef_b_act_reg <= {coef_b_hi_reg, coef_b_lo_reg};
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
    begin
      // commit bits are not stored and read back as zero
      case (i_reg_addr)
        rpf_pkg::ADDR_PWR_ONE: o_reg_rdata <= pwr_one_reg;
        rpf_pkg::ADDR_PWR_TWO: o_reg_rdata <= pwr_two_reg;
        rpf_pkg::ADDR_CONV_CTRL: o_reg_rdata <= conv_ctrl_reg;
        rpf_pkg::ADDR_GAIN: o_reg_rdata <= {1'b0, gain_code_reg};
        rpf_pkg::ADDR_COEF_A_LO: o_reg_rdata <= {1'b0, notch_en_reg, coef_a_lo_reg};
        rpf_pkg::ADDR_COEF_A_HI: o_reg_rdata <= {2'b00, coef_a_hi_reg};
        rpf_pkg::ADDR_COEF_B_LO: o_reg_rdata <= {2'b00, coef_b_lo_reg};
        rpf_pkg::ADDR_COEF_B_HI: o_reg_rdata <= {2'b00, coef_b_hi_reg};
        rpf_pkg::ADDR_ROUTING: o_reg_rdata <= routing_reg;
        rpf_pkg::ADDR_AMP_VOL: o_reg_rdata <= amp_vol_reg;
        rpf_pkg::ADDR_MIX: o_reg_rdata <= mix_reg;
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  logic isolate;
  assign isolate = amp_vol_reg[rpf_pkg::BIT_ISOLATE];
  assign o_amp_path_connect = !isolate;
  assign o_amp_path_boost = mix_reg[rpf_pkg::BIT_BOOST] && !isolate;
  assign o_aux_gain_code = mix_reg[rpf_pkg::AUX_LSB +: 3];
  assign o_aux_connect = |mix_reg[rpf_pkg::AUX_LSB +: 3];
  assign o_line_gain_code = mix_reg[rpf_pkg::LINE_LSB +: 3];
  assign o_line_connect = |mix_reg[rpf_pkg::LINE_LSB +: 3];
  assign o_mix_stage_power = pwr_two_reg[rpf_pkg::BIT_MIX_EN];
  assign o_bias_drive_en = pwr_one_reg[rpf_pkg::BIT_BIAS_EN];
  assign o_bias_level_low = routing_reg[rpf_pkg::BIT_BIAS_LVL];
  assign o_converter_power = conv_en;
  assign o_oversample_128 = conv_ctrl_reg[rpf_pkg::BIT_OSR];

  // boxcar decimator; ratio follows the oversample setting
  logic [6:0] dec_cnt_reg;
  logic signed [rpf_pkg::DECW-1:0] dec_acc_reg, dec_sum;
  assign dec_sum = dec_acc_reg + rpf_pkg::DECW'(i_mod_data);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dec_cnt_reg <= '0;
      dec_acc_reg <= '0;
      dec_valid <= 1'b0;
      dec_data <= '0;
    end
    else if (!conv_en)
    begin
      dec_cnt_reg <= '0;
      dec_acc_reg <= '0;
      dec_valid <= 1'b0;
    end
    else
    begin
      dec_valid <= 1'b0;
      if (i_mod_valid)
      begin
        if (dec_cnt_reg == (o_oversample_128 ? rpf_pkg::OSR_HI_LAST : rpf_pkg::OSR_LO_LAST))
        begin
          dec_cnt_reg <= '0;
          dec_acc_reg <= '0;
          dec_valid <= 1'b1;
          dec_data <= o_oversample_128 ? DW'(dec_sum) <<< rpf_pkg::DEC_SHIFT_HI
            : DW'(dec_sum) <<< rpf_pkg::DEC_SHIFT_LO;
        end
        else
        begin
          dec_cnt_reg <= dec_cnt_reg + 7'h01;
          dec_acc_reg <= dec_sum;
        end
      end
    end
  end

  // invert then high-pass; application mode cascades two leaky sections
  logic hpf_en, hpf_app, h_valid;
  logic [4:0] hpf_shift;
  logic signed [HW-1:0] hx_in, hx1_reg, hy1_reg, hy2_reg, hy1, hy2;
  logic signed [DW-1:0] h_data;
  assign hpf_en = conv_ctrl_reg[rpf_pkg::BIT_HPF_EN];
  assign hpf_app = conv_ctrl_reg[rpf_pkg::BIT_HPF_APP];
  assign hpf_shift = hpf_app ? rpf_pkg::hpf_app_shift(conv_ctrl_reg[rpf_pkg::HPF_CUT_LSB +: 3])
    : rpf_pkg::HPF_AUDIO_SHIFT;
  assign hx_in = conv_ctrl_reg[rpf_pkg::BIT_INVERT] ? -HW'(dec_data) : HW'(dec_data);
  assign hy1 = hx_in - hx1_reg + hy1_reg - (hy1_reg >>> hpf_shift);
  assign hy2 = hy1 - hy1_reg + hy2_reg - (hy2_reg >>> hpf_shift);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hx1_reg <= '0;
      hy1_reg <= '0;
      hy2_reg <= '0;
      h_valid <= 1'b0;
      h_data <= '0;
    end
    else if (!conv_en)
    begin
      hx1_reg <= '0;
      hy1_reg <= '0;
      hy2_reg <= '0;
      h_valid <= 1'b0;
    end
    else
    begin
      h_valid <= dec_valid;
      if (dec_valid)
      begin
        hx1_reg <= hx_in;
        hy1_reg <= hy1;
        hy2_reg <= hy2;
        if (!hpf_en)
          h_data <= sat(ACCW'(hx_in));
        else if (hpf_app)
          h_data <= sat(ACCW'(hy2));
        else
          h_data <= sat(ACCW'(hy1));
      end
    end
  end

  // notch = half of (input + allpass); allpass uses a0 = -A/2^13, a1 = -B/2^12
  logic n_valid;
  logic signed [DW-1:0] n_data, nx1_reg, nx2_reg, nap1_reg, nap2_reg, nap;
  logic signed [ACCW-1:0] n_acc, n_mix;

  always_comb
  begin
    n_acc = -(ACCW'(coef_a_act_reg) * ACCW'(h_data))
      - ((ACCW'(coef_b_act_reg) * ACCW'(nx1_reg)) <<< 1)
      + (ACCW'(nx2_reg) <<< rpf_pkg::NOTCH_A_FRAC)
      + ((ACCW'(coef_b_act_reg) * ACCW'(nap1_reg)) <<< 1)
      + ACCW'(coef_a_act_reg) * ACCW'(nap2_reg);
    nap = sat(n_acc >>> rpf_pkg::NOTCH_A_FRAC);
    n_mix = (ACCW'(h_data) + ACCW'(nap)) >>> 1;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      nx1_reg <= '0;
      nx2_reg <= '0;
      nap1_reg <= '0;
      nap2_reg <= '0;
      n_valid <= 1'b0;
      n_data <= '0;
    end
    else if (!conv_en)
    begin
      nx1_reg <= '0;
      nx2_reg <= '0;
      nap1_reg <= '0;
      nap2_reg <= '0;
      n_valid <= 1'b0;
    end
    else
    begin
      n_valid <= h_valid;
      if (h_valid)
      begin
        nx1_reg <= h_data;
        nx2_reg <= nx1_reg;
        nap1_reg <= nap;
        nap2_reg <= nap1_reg;
        n_data <= notch_en_reg ? sat(n_mix) : h_data;
      end
    end
  end

  // gain = mantissa for the half-dB remainder, then one shift per 6dB
  logic [7:0] g_att, g_oct, g_rem;
  logic signed [ACCW-1:0] g_prod;
  assign g_att = rpf_pkg::GAIN_UNITY - gain_act_reg;
  assign g_oct = g_att / rpf_pkg::GAIN_STEPS_6DB;
  assign g_rem = g_att % rpf_pkg::GAIN_STEPS_6DB;
  assign g_prod = (ACCW'(n_data) * ACCW'(rpf_pkg::gain_mantissa(g_rem))) >>> rpf_pkg::MANT_FRAC;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_smp_valid <= 1'b0;
      o_smp_data <= '0;
    end
    else if (!conv_en)
      o_smp_valid <= 1'b0;
    else
    begin
      o_smp_valid <= n_valid;
      if (n_valid)
      begin
        if (gain_act_reg == rpf_pkg::GAIN_MUTE)
          o_smp_data <= '0;
        else
          o_smp_data <= DW'(g_prod >>> g_oct);
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_gain_commit_write;
    i_reg_wr && i_reg_addr == rpf_pkg::ADDR_GAIN && i_reg_wdata[rpf_pkg::BIT_COMMIT];
  endsequence
  sequence s_chain_run;
    dec_valid && conv_en ##1 conv_en [*2];
  endsequence

  a_gain_commit_only: assert property ($changed(gain_act_reg) |-> $past(gain_commit))
    else $error("gain applied without commit");
  a_gain_commit_value: assert property (s_gain_commit_write |=> gain_act_reg == $past(i_reg_wdata[7:0]))
    else $error("committed gain not applied");
  a_gain_mute_zero: assert property (n_valid && conv_en && gain_act_reg == rpf_pkg::GAIN_MUTE
    |=> o_smp_valid && o_smp_data == '0)
    else $error("mute code let samples through");
  a_gain_unity_pass: assert property (n_valid && conv_en && gain_act_reg == rpf_pkg::GAIN_UNITY
    |=> o_smp_data == $past(n_data))
    else $error("unity gain altered sample");
  a_notch_load_point: assert property ($changed(coef_a_act_reg) || $changed(coef_b_act_reg)
    |-> $past(notch_pending_reg && dec_valid))
    else $error("notch coefficients changed off commit boundary");
  a_notch_bypass_pass: assert property (h_valid && conv_en && !notch_en_reg
    |=> n_valid && n_data == $past(h_data))
    else $error("disabled notch altered sample");
  a_hpf_bypass_pass: assert property (dec_valid && conv_en && !hpf_en
    && !conv_ctrl_reg[rpf_pkg::BIT_INVERT] |=> h_data == $past(dec_data))
    else $error("bypassed high-pass altered sample");
  a_invert_polarity: assert property (dec_valid && conv_en && !hpf_en
    && conv_ctrl_reg[rpf_pkg::BIT_INVERT] && dec_data != {1'b1, {(DW-1){1'b0}}}
    |=> h_data == -$past(dec_data))
    else $error("polarity not inverted");
  a_conv_off_quiet: assert property (!conv_en |=> !dec_valid && !o_smp_valid)
    else $error("samples while converter disabled");
  a_chain_latency: assert property (s_chain_run |=> o_smp_valid)
    else $error("sample did not leave three cycles after decimation");
  a_amp_isolate: assert property (isolate |-> !o_amp_path_connect && !o_amp_path_boost)
    else $error("isolated amp path still boosted");
endmodule // rpf_record_path
`default_nettype wire

// *** verif/rpf_mod_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module rpf_mod_source (
  // control from the bench
  input wire logic i_run,
  input wire logic signed [rpf_pkg::MODW-1:0] i_level,
  // oversampled words toward the block
  output logic o_valid,
  output logic signed [rpf_pkg::MODW-1:0] o_data
);
  // a word every cycle while running, the fastest order allowed
  assign o_valid = i_run;
  // idle line shows the inverse, so data latched outside a strobe shows up
  assign o_data = i_run ? i_level : ~i_level;
endmodule // rpf_mod_source
`default_nettype wire

// *** verif/record_path_filter_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module record_path_filter_control_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [8:0] wdata = 9'h000;
  logic run = 1'b0;
  logic signed [3:0] lvl = 4'h0;
  wire logic mv;
  wire logic signed [3:0] md;
  wire logic [8:0] rdata;
  wire logic sv;
  wire logic signed [23:0] sd;
  wire logic [14:0] ctl;
  wire logic [2:0] auxc;
  wire logic [2:0] linec;
  wire logic ac, ab, xc, lc, mp, be, bl, cp, os;
  int n_errors = 0;
  int cmp_count = 0;
  assign ctl = {ac, ab, xc, auxc, lc, linec, mp, be, bl, cp, os};
  always #2.5 clk = ~clk;

  rpf_mod_source src_u (.i_run(run), .i_level(lvl), .o_valid(mv), .o_data(md));
  rpf_record_path dut_u (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_mod_valid(mv), .i_mod_data(md), .o_smp_valid(sv), .o_smp_data(sd),
    .o_amp_path_connect(ac), .o_amp_path_boost(ab), .o_aux_connect(xc),
    .o_aux_gain_code(auxc), .o_line_connect(lc), .o_line_gain_code(linec),
    .o_mix_stage_power(mp), .o_bias_drive_en(be), .o_bias_level_low(bl),
    .o_converter_power(cp), .o_oversample_128(os)
  );

  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [8:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // last of n samples is taken so filter and decimator history is flushed
  task automatic get_smp(input int n, output logic [23:0] s);
    int i;
    repeat (n)
    begin
      for (i = 0; i < 3000; i++)
      begin
        @(negedge clk);
        if (sv === 1'b1)
          break;
      end
      s = sd;
      if (i == 3000)
      begin
        n_errors++;
        end_of_test();
      end
    end
  endtask

  function automatic logic [23:0] exp_smp(input int d, input bit inv, input logic [7:0] g);
    int v;
    v = d <<< 20;
    if (inv)
      v = -v;
    if (g == 8'h00)
      v = 0;
    else if (g == 8'hF3)
      v = v >>> 1;
    return 24'(v);
  endfunction

  initial
  begin
    logic [8:0] r, a, b, c, e, f;
    logic [23:0] s;
    int d, k, cnt;
    bit iso;
    logic [6:0] ra [8] = '{7'h01, 7'h02, 7'h0E, 7'h0F, 7'h1B, 7'h2C, 7'h2F, 7'h7F};
    logic [8:0] rv [8] = '{9'h000, 9'h000, 9'h100, 9'h0FF, 9'h000, 9'h003, 9'h100, 9'h000};
    logic [2:0] cs [5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h0};
    logic [7:0] gs [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hF3, 8'h00};
    void'($urandom(43));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("ctl_reset", 24'(ctl), 24'h006000);
    for (k = 0; k < 8; k++)
    begin
      rd_reg(ra[k], r);
      chk("reset_read", 24'(r), 24'(rv[k]));
    end
    for (k = 0; k < 8; k++)
    begin
      a = 9'($urandom);
      b = 9'($urandom);
      c = 9'($urandom);
      e = 9'($urandom);
      f = 9'($urandom);
      iso = (k % 3 == 1);
      wr_reg(7'h2F, a);
      wr_reg(7'h2C, b);
      wr_reg(7'h01, c);
      wr_reg(7'h02, e);
      wr_reg(7'h0E, f);
      wr_reg(7'h2D, {2'h0, iso, 6'h10});
      chk("ctl", 24'(ctl), 24'({!iso, a[8] & !iso, |a[2:0], a[2:0], |a[6:4], a[6:4],
        e[4], c[4], b[8], e[0], f[3]}));
      rd_reg(7'h2F, r);
      chk("mix_read", 24'(r), 24'(a));
    end
    wr_reg(7'h2D, 9'h010);
    // all four halves first, commit only on the last write
    a = 9'($urandom) & 9'h07F;
    b = 9'($urandom) & 9'h07F;
    wr_reg(7'h1B, a);
    wr_reg(7'h1C, b);
    wr_reg(7'h1D, b ^ 9'h055);
    wr_reg(7'h1E, a | 9'h100);
    rd_reg(7'h1B, r);
    chk("coef_lo", 24'(r), 24'(a));
    rd_reg(7'h1E, r);
    chk("coef_hi", 24'(r), 24'(a));
    wr_reg(7'h02, 9'h001);
    @(posedge clk);
    run <= 1'b1;
    for (k = 0; k < 5; k++)
    begin
      d = int'($urandom % 14) - 7;
      @(posedge clk);
      lvl <= 4'(d);
      // rate group stays at its 48kHz default throughout
      wr_reg(7'h0E, {6'h00, cs[k]});
      wr_reg(7'h0F, {1'b1, gs[k]});
      get_smp(3, s);
      chk("sample", s, exp_smp(d, cs[k][0], gs[k]));
    end
    wr_reg(7'h0F, 9'h0FF);
    get_smp(3, s);
    chk("gain_staged", s, 24'h000000);
    wr_reg(7'h02, 9'h000);
    repeat (10) @(posedge clk);
    cnt = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (sv !== 1'b0)
        cnt++;
    end
    chk("idle_samples", 24'(cnt), 24'h0);
    wr_reg(7'h02, 9'h001);
    wr_reg(7'h0F, 9'h1FF);
    @(posedge clk);
    lvl <= 4'sh7;
    wr_reg(7'h0E, 9'h1F0);
    get_smp(200, s);
    chk("hpf_decay", 24'($signed(s) < 24'sh100000 && $signed(s) > -24'sh100000), 24'h1);
    end_of_test();
  end
endmodule // record_path_filter_control_test
`default_nettype wire
